//--- common/ppd_pin_if.sv
// Interface carrying raw pins to the synchroniser and stable levels back.
`timescale 1ns/100ps
`default_nettype none
interface ppd_pin_if #(
  parameter int unsigned W = 25
);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface : ppd_pin_if
`default_nettype wire

//--- common/ppd_pkg.sv
// Constants, types and helpers shared by the parallel port D to H block.
package ppd_pkg;
  localparam int unsigned IDX_W = 8;
  localparam logic [7:0] IDX_F_DIR = 8'h03;
  localparam logic [7:0] IDX_F_VAL = 8'h05;
  localparam logic [7:0] IDX_D_DIR = 8'h09;
  localparam logic [7:0] IDX_E_VAL = 8'h0A;
  localparam logic [7:0] IDX_PULLUP = 8'h2C;
  localparam logic [7:0] IDX_G_ASG = 8'h2D;
  localparam logic [7:0] IDX_G_VAL = 8'h7E;
  localparam logic [7:0] IDX_G_DIR = 8'h7F;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [5:0] G_LOW_RST = 6'h00;
  localparam logic [3:0] PULLUP_RST = 4'hF;
  localparam int unsigned PU_B = 0;
  localparam int unsigned PU_F = 1;
  localparam int unsigned PU_G = 2;
  localparam int unsigned PU_H = 3;
  localparam int unsigned G_LOW_W = 6;
  localparam int unsigned PIN_W = 25;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } ppd_bus_e;
  // Output bits show the latch, input bits show the synchronised pin.
  function automatic logic [7:0] ppd_mix(input logic [7:0] dir,
                                         input logic [7:0] latch,
                                         input logic [7:0] pin);
    ppd_mix = (dir & latch) | (~dir & pin);
  endfunction : ppd_mix
endpackage : ppd_pkg

//--- tb/ppd_pins_model.sv
// Behavioural model of the external pins around the parallel ports.
`timescale 1ns/100ps
`default_nettype none
module ppd_pins_model (
  // Clock.
  input wire logic clock_i,
  // Levels driven from outside, and release of the port F lines.
  input wire logic [7:0] ext_e_i,
  input wire logic [7:0] ext_f_i,
  input wire logic [7:0] ext_g_i,
  input wire logic float_i,
  // Device side of the pads.
  input wire logic [7:0] f_out_i,
  input wire logic [7:0] f_oe_i,
  input wire logic [7:0] f_pu_i,
  input wire logic [5:0] g_out_i,
  input wire logic [5:0] g_oe_i,
  input wire logic [5:0] g_pu_i,
  output logic [7:0] e_pin_o,
  output logic [7:0] f_pin_o,
  output logic [7:0] g_pin_o
);
  // A released port F line with no pull-up wanders while float_i is high, so it toggles every cycle.
  logic wander_q = 1'b0;
  always @(posedge clock_i) begin
    wander_q <= ~wander_q;
  end
  // Port E has no drivers, so only the outside sets its level.
  assign e_pin_o = ext_e_i;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      f_pin_o[i] = f_oe_i[i] ? f_out_i[i] :
                   float_i ? (f_pu_i[i] | wander_q) : ext_f_i[i];
    end
    for (int i = 0; i < 6; i++) begin
      g_pin_o[i] = g_oe_i[i] ? g_out_i[i] : ext_g_i[i];
    end
    g_pin_o[7:6] = ext_g_i[7:6];
  end
endmodule : ppd_pins_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench for the parallel port D to H block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic expanded_mode_i = 1'b0;
  logic [7:0] low_address_i = 8'hC3;
  logic [5:0] extended_address_i = 6'h15;
  logic [7:0] port_h_gp_data_i = 8'h3C;
  logic [7:0] port_h_gp_oe_i = 8'h00;
  logic [3:0] chip_select_i = 4'hA;
  logic [3:0] chip_select_en_i = 4'h0;
  logic [3:0] pulse_width_i = 4'h5;
  logic [3:0] pulse_width_en_i = 4'h0;
  logic [7:0] ext_e = 8'h3C;
  logic [7:0] ext_f = 8'h33;
  logic [7:0] ext_g = 8'h80;
  logic float_f = 1'b1;
  logic [7:0] port_d_dir_bits_o, port_e_pins_i, port_f_pins_i, port_g_pins_i;
  logic [7:0] port_f_pins_o, port_f_pins_oe_o, port_f_pullup_o;
  logic [5:0] port_g_pins_o, port_g_pins_oe_o, port_g_pullup_o;
  logic [7:0] port_h_pins_o, port_h_pins_oe_o, port_h_pullup_o;
  logic port_b_pullup_o;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clock_i = ~clock_i;

  ppd_ports u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .expanded_mode_i(expanded_mode_i), .port_d_dir_bits_o(port_d_dir_bits_o),
    .port_e_pins_i(port_e_pins_i), .port_f_pins_i(port_f_pins_i),
    .port_f_pins_o(port_f_pins_o), .port_f_pins_oe_o(port_f_pins_oe_o),
    .port_f_pullup_o(port_f_pullup_o), .low_address_i(low_address_i),
    .port_g_pins_i(port_g_pins_i), .port_g_pins_o(port_g_pins_o),
    .port_g_pins_oe_o(port_g_pins_oe_o), .port_g_pullup_o(port_g_pullup_o),
    .extended_address_i(extended_address_i),
    .port_h_gp_data_i(port_h_gp_data_i), .port_h_gp_oe_i(port_h_gp_oe_i),
    .chip_select_i(chip_select_i), .chip_select_en_i(chip_select_en_i),
    .pulse_width_i(pulse_width_i), .pulse_width_en_i(pulse_width_en_i),
    .port_h_pins_o(port_h_pins_o), .port_h_pins_oe_o(port_h_pins_oe_o),
    .port_h_pullup_o(port_h_pullup_o), .port_b_pullup_o(port_b_pullup_o)
  );

  ppd_pins_model u_pins (
    .clock_i(clock_i), .ext_e_i(ext_e), .ext_f_i(ext_f), .ext_g_i(ext_g),
    .float_i(float_f), .f_out_i(port_f_pins_o), .f_oe_i(port_f_pins_oe_o),
    .f_pu_i(port_f_pullup_o), .g_out_i(port_g_pins_o),
    .g_oe_i(port_g_pins_oe_o), .g_pu_i(port_g_pullup_o),
    .e_pin_o(port_e_pins_i), .f_pin_o(port_f_pins_i), .g_pin_o(port_g_pins_i)
  );

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // The whole run needs well under a thousand cycles.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, wd};
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask : wr

  task automatic rdchk(input string name, input logic [7:0] idx,
                       input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    check(name, r, {24'h000000, exp});
  endtask : rdchk

  // Pin inputs pass a synchroniser, so give them a few cycles to land.
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
  endtask : settle

  // Held longer than three cycles because the mode strap is synchronised.
  task automatic do_reset(input logic mode);
    sys_rst_i <= 1'b1;
    expanded_mode_i <= mode;
    settle(6);
    sys_rst_i <= 1'b0;
    settle(1);
  endtask : do_reset

  initial begin
    do_reset(1'b0);
    rdchk("d_dir", ppd_pkg::IDX_D_DIR, 8'h00);
    rdchk("f_dir", ppd_pkg::IDX_F_DIR, 8'h00);
    rdchk("g_dir", ppd_pkg::IDX_G_DIR, 8'h00);
    rdchk("g_asg", ppd_pkg::IDX_G_ASG, 8'h00);
    rdchk("pullup", ppd_pkg::IDX_PULLUP, 8'h0F);
    rdchk("unmapped", 8'h10, 8'h00);
    rdchk("f_float", ppd_pkg::IDX_F_VAL, 8'hFF);
    check("f_oe", 32'(port_f_pins_oe_o), 32'h00);
    check("g_pu", 32'(port_g_pullup_o), 32'h3F);
    check("b_pu", 32'(port_b_pullup_o), 32'h1);
    $display("Test reset state done");
    wr(ppd_pkg::IDX_D_DIR, 8'hA5);
    rdchk("d_dir", ppd_pkg::IDX_D_DIR, 8'hA5);
    check("d_out", 32'(port_d_dir_bits_o), 32'hA5);
    // No converter is modelled, so port reads never meet a sample phase.
    rdchk("e_val", ppd_pkg::IDX_E_VAL, 8'h3C);
    wr(ppd_pkg::IDX_E_VAL, 8'hFF);
    ext_e <= 8'hC3;
    settle(8);
    rdchk("e_val", ppd_pkg::IDX_E_VAL, 8'hC3);
    $display("Test ports D and E done");
    float_f <= 1'b0;
    wr(ppd_pkg::IDX_F_VAL, 8'h5A);
    wr(ppd_pkg::IDX_F_DIR, 8'hF0);
    settle(8);
    check("f_out", 32'(port_f_pins_o & 8'hF0), 32'h50);
    check("f_oe", 32'(port_f_pins_oe_o), 32'hF0);
    check("f_pu", 32'(port_f_pullup_o), 32'h0F);
    rdchk("f_val", ppd_pkg::IDX_F_VAL, 8'h53);
    $display("Test port F done");
    wr(ppd_pkg::IDX_G_DIR, 8'hFF);
    rdchk("g_dir", ppd_pkg::IDX_G_DIR, 8'h3F);
    wr(ppd_pkg::IDX_G_ASG, 8'hFF);
    rdchk("g_asg", ppd_pkg::IDX_G_ASG, 8'h3F);
    wr(ppd_pkg::IDX_G_ASG, 8'h05);
    wr(ppd_pkg::IDX_G_VAL, 8'h2A);
    settle(8);
    check("g_out", 32'(port_g_pins_o), 32'h2F);
    check("g_oe", 32'(port_g_pins_oe_o), 32'h3F);
    rdchk("g_val", ppd_pkg::IDX_G_VAL, 8'hAA);
    wr(ppd_pkg::IDX_G_VAL, 8'h00);
    settle(3);
    check("g_out", 32'(port_g_pins_o), 32'h05);
    wr(ppd_pkg::IDX_G_DIR, 8'h00);
    wr(ppd_pkg::IDX_PULLUP, 8'hFB);
    rdchk("pullup", ppd_pkg::IDX_PULLUP, 8'h0B);
    settle(3);
    check("g_pu", 32'(port_g_pullup_o), 32'h00);
    check("g_oe", 32'(port_g_pins_oe_o), 32'h05);
    $display("Test port G done");
    check("h_pu", 32'(port_h_pullup_o), 32'hFF);
    chip_select_en_i <= 4'hF;
    pulse_width_en_i <= 4'hF;
    settle(3);
    check("h_out", 32'(port_h_pins_o), 32'hA5);
    check("h_oe", 32'(port_h_pins_oe_o), 32'hFF);
    $display("Test port H done");
    do_reset(1'b1);
    settle(2);
    check("f_addr", 32'(port_f_pins_o), 32'hC3);
    check("f_oe", 32'(port_f_pins_oe_o), 32'hFF);
    check("b_pu", 32'(port_b_pullup_o), 32'h0);
    wr(ppd_pkg::IDX_F_DIR, 8'hFF);
    rdchk("f_dir", ppd_pkg::IDX_F_DIR, 8'h00);
    $display("Test expanded mode done");
    conclude();
  end
endmodule : tb
`default_nettype wire

//--- verilog/ppd_ports.sv
// Register-mapped parallel ports D to H with an Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none
module ppd_ports (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave, byte addressed.
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Mode strap, high for expanded or test mode.
  input wire logic expanded_mode_i,
  // Port D.
  output logic [7:0] port_d_dir_bits_o,
  // Port E.
  input wire logic [7:0] port_e_pins_i,
  // Port F and low address.
  input wire logic [7:0] port_f_pins_i,
  output logic [7:0] port_f_pins_o,
  output logic [7:0] port_f_pins_oe_o,
  output logic [7:0] port_f_pullup_o,
  input wire logic [7:0] low_address_i,
  // Port G and extended address.
  input wire logic [7:0] port_g_pins_i,
  output logic [5:0] port_g_pins_o,
  output logic [5:0] port_g_pins_oe_o,
  output logic [5:0] port_g_pullup_o,
  input wire logic [5:0] extended_address_i,
  // Port H general purpose and alternate sources.
  input wire logic [7:0] port_h_gp_data_i,
  input wire logic [7:0] port_h_gp_oe_i,
  input wire logic [3:0] chip_select_i,
  input wire logic [3:0] chip_select_en_i,
  input wire logic [3:0] pulse_width_i,
  input wire logic [3:0] pulse_width_en_i,
  output logic [7:0] port_h_pins_o,
  output logic [7:0] port_h_pins_oe_o,
  output logic [7:0] port_h_pullup_o,
  // Port B pull-up.
  output logic port_b_pullup_o
);
  ppd_pin_if #(.W(ppd_pkg::PIN_W)) pins ();

  logic [7:0] e_stable;
  logic [7:0] f_stable;
  logic [7:0] g_stable;
  logic mode_stable;

  assign pins.raw = {expanded_mode_i, port_g_pins_i, port_f_pins_i,
                     port_e_pins_i};
  assign e_stable = pins.stable[7:0];
  assign f_stable = pins.stable[15:8];
  assign g_stable = pins.stable[23:16];
  assign mode_stable = pins.stable[24];

  ppd_sync #(.W(ppd_pkg::PIN_W)) u_sync (
    .clock_i(clock_i),
    .pins(pins)
  );

  // Mode strap, caught while reset is held.
  logic mode_q;
  logic mode_d;

  always_comb begin
    mode_d = sys_rst_i ? mode_stable : mode_q;
  end

  always_ff @(posedge clock_i) begin
    mode_q <= mode_d;
  end

  // Bus handshake.
  ppd_pkg::ppd_bus_e st_q;
  ppd_pkg::ppd_bus_e st_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] idx;
  logic [7:0] rd_val;
  logic wr_go;
  logic [7:0] wdata;

  assign idx = avs_address_i[ppd_pkg::IDX_LSB +: ppd_pkg::IDX_W];
  assign wdata = avs_writedata_i[7:0];
  // A write lands on the edge where the master sees waitrequest low.
  assign wr_go = (st_q == ppd_pkg::ST_ACK) && avs_write_i;

  // Configuration registers.
  logic [7:0] d_dir_q;
  logic [7:0] d_dir_d;
  logic [7:0] f_dir_q;
  logic [7:0] f_dir_d;
  logic [5:0] g_dir_q;
  logic [5:0] g_dir_d;
  logic [5:0] g_asg_q;
  logic [5:0] g_asg_d;
  logic [3:0] pu_q;
  logic [3:0] pu_d;
  // Data latches, never reset.
  logic [7:0] f_val_q;
  logic [7:0] f_val_d;
  logic [7:0] g_val_q;
  logic [7:0] g_val_d;

  // Read multiplexer; port F vanishes from the map in expanded mode.
  always_comb begin
    rd_val = '0;
    unique case (idx)
      ppd_pkg::IDX_D_DIR: rd_val = d_dir_q;
      ppd_pkg::IDX_E_VAL: rd_val = e_stable;
      ppd_pkg::IDX_F_DIR: begin
        if (!mode_q) begin
          rd_val = f_dir_q;
        end
      end
      ppd_pkg::IDX_F_VAL: begin
        if (!mode_q) begin
          rd_val = ppd_pkg::ppd_mix(f_dir_q, f_val_q, f_stable);
        end
      end
      ppd_pkg::IDX_G_VAL: begin
        // Pins seven and six have no direction bit and always read the pin.
        rd_val = ppd_pkg::ppd_mix({2'b00, g_dir_q}, g_val_q,
                                  g_stable);
      end
      ppd_pkg::IDX_G_DIR: rd_val = {2'b00, g_dir_q};
      ppd_pkg::IDX_G_ASG: rd_val = {2'b00, g_asg_q};
      ppd_pkg::IDX_PULLUP: rd_val = {4'h0, pu_q};
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    unique case (st_q)
      ppd_pkg::ST_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          st_d = ppd_pkg::ST_ACK;
          wait_d = 1'b0;
          rdata_d = avs_read_i ? {24'h000000, rd_val} : '0;
        end
      end
      ppd_pkg::ST_ACK: begin
        st_d = ppd_pkg::ST_IDLE;
        wait_d = 1'b1;
      end
      default: begin
        st_d = ppd_pkg::ST_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_q <= ppd_pkg::ST_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Register writes.
  always_comb begin
    d_dir_d = d_dir_q;
    f_dir_d = f_dir_q;
    g_dir_d = g_dir_q;
    g_asg_d = g_asg_q;
    pu_d = pu_q;
    f_val_d = f_val_q;
    g_val_d = g_val_q;
    if (wr_go) begin
      unique case (idx)
        ppd_pkg::IDX_D_DIR: d_dir_d = wdata;
        ppd_pkg::IDX_F_DIR: begin
          if (!mode_q) begin
            f_dir_d = wdata;
          end
        end
        ppd_pkg::IDX_F_VAL: begin
          if (!mode_q) begin
            f_val_d = wdata;
          end
        end
        // Latch always takes the write; the pin mux decides what shows.
        ppd_pkg::IDX_G_VAL: g_val_d = wdata;
        ppd_pkg::IDX_G_DIR: g_dir_d = wdata[5:0];
        ppd_pkg::IDX_G_ASG: g_asg_d = wdata[5:0];
        ppd_pkg::IDX_PULLUP: pu_d = wdata[3:0];
        default: begin
          d_dir_d = d_dir_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      d_dir_q <= ppd_pkg::DIR_RST;
      f_dir_q <= ppd_pkg::DIR_RST;
      g_dir_q <= ppd_pkg::G_LOW_RST;
      g_asg_q <= ppd_pkg::G_LOW_RST;
      pu_q <= ppd_pkg::PULLUP_RST;
    end else begin
      d_dir_q <= d_dir_d;
      f_dir_q <= f_dir_d;
      g_dir_q <= g_dir_d;
      g_asg_q <= g_asg_d;
      pu_q <= pu_d;
    end
  end

  // Data latches keep their content through reset.
  always_ff @(posedge clock_i) begin
    f_val_q <= f_val_d;
    g_val_q <= g_val_d;
  end

  // Pin drivers. Port E has no driver at all, so it is always an input.
  logic [7:0] f_out_d;
  logic [7:0] f_oe_d;
  logic [7:0] f_pu_d;
  logic [5:0] g_out_d;
  logic [5:0] g_oe_d;
  logic [5:0] g_pu_d;
  logic [7:0] h_sel;
  logic [7:0] h_out_d;
  logic [7:0] h_oe_d;
  logic [7:0] h_pu_d;
  logic b_pu_d;

  always_comb begin
    if (mode_q) begin
      f_out_d = low_address_i;
      f_oe_d = '1;
      f_pu_d = '0;
    end else begin
      f_out_d = f_val_q;
      f_oe_d = f_dir_q;
      f_pu_d = {8{pu_q[ppd_pkg::PU_F]}} & ~f_dir_q;
    end
    g_out_d = (g_asg_q & extended_address_i) |
              (~g_asg_q & g_val_q[5:0]);
    g_oe_d = g_asg_q | g_dir_q;
    g_pu_d = {ppd_pkg::G_LOW_W{pu_q[ppd_pkg::PU_G]}} & ~g_oe_d;
    h_sel = {chip_select_en_i, pulse_width_en_i};
    h_out_d = (h_sel & {chip_select_i, pulse_width_i}) |
              (~h_sel & port_h_gp_data_i);
    h_oe_d = h_sel | port_h_gp_oe_i;
    h_pu_d = {8{pu_q[ppd_pkg::PU_H]}} & ~h_oe_d;
    // Port B pull-ups mean nothing once B carries the high address.
    b_pu_d = pu_q[ppd_pkg::PU_B] & ~mode_q;
  end

  logic [7:0] f_out_q;
  logic [7:0] f_oe_q;
  logic [7:0] f_pu_q;
  logic [5:0] g_out_q;
  logic [5:0] g_oe_q;
  logic [5:0] g_pu_q;
  logic [7:0] h_out_q;
  logic [7:0] h_oe_q;
  logic [7:0] h_pu_q;
  logic b_pu_q;

  // Drivers are registered, so pins follow their sources one cycle late.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      f_out_q <= '0;
      f_oe_q <= '0;
      f_pu_q <= '0;
      g_out_q <= '0;
      g_oe_q <= '0;
      g_pu_q <= '0;
      h_out_q <= '0;
      h_oe_q <= '0;
      h_pu_q <= '0;
      b_pu_q <= 1'b0;
    end else begin
      f_out_q <= f_out_d;
      f_oe_q <= f_oe_d;
      f_pu_q <= f_pu_d;
      g_out_q <= g_out_d;
      g_oe_q <= g_oe_d;
      g_pu_q <= g_pu_d;
      h_out_q <= h_out_d;
      h_oe_q <= h_oe_d;
      h_pu_q <= h_pu_d;
      b_pu_q <= b_pu_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign port_d_dir_bits_o = d_dir_q;
  assign port_f_pins_o = f_out_q;
  assign port_f_pins_oe_o = f_oe_q;
  assign port_f_pullup_o = f_pu_q;
  assign port_g_pins_o = g_out_q;
  assign port_g_pins_oe_o = g_oe_q;
  assign port_g_pullup_o = g_pu_q;
  assign port_h_pins_o = h_out_q;
  assign port_h_pins_oe_o = h_oe_q;
  assign port_h_pullup_o = h_pu_q;
  assign port_b_pullup_o = b_pu_q;

  // Checks.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_req;
    (st_q == ppd_pkg::ST_IDLE) && (avs_read_i || avs_write_i);
  endsequence

  sequence s_rd(logic [7:0] at);
    (st_q == ppd_pkg::ST_IDLE) && avs_read_i && (idx == at);
  endsequence

  a_reset_regs: assert property (
    @(posedge clock_i) disable iff (1'b0)
    sys_rst_i |=> (d_dir_q == ppd_pkg::DIR_RST) &&
      (f_dir_q == ppd_pkg::DIR_RST) && (g_dir_q == ppd_pkg::G_LOW_RST) &&
      (g_asg_q == ppd_pkg::G_LOW_RST) && (pu_q == ppd_pkg::PULLUP_RST))
    else $error("Configuration registers wrong after reset.");

  a_bus_answer: assert property (
    s_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Bus answer not exactly one cycle after request.");

  a_e_read_pins: assert property (
    s_rd(ppd_pkg::IDX_E_VAL) |=> avs_readdata_o[7:0] == $past(e_stable))
    else $error("Port E read does not return the pins.");

  a_f_addr_out: assert property (
    mode_q |=> (port_f_pins_o == $past(low_address_i)) &&
      (port_f_pins_oe_o == 8'hFF))
    else $error("Port F does not drive the low address.");

  a_f_unmapped: assert property (
    s_rd(ppd_pkg::IDX_F_DIR) ##0 mode_q |=> avs_readdata_o == 32'h00000000)
    else $error("Port F direction visible in expanded mode.");

  a_f_input_pullup: assert property (
    !mode_q && (f_dir_q == 8'h00) |=> (port_f_pins_oe_o == 8'h00) &&
      (port_f_pullup_o == {8{$past(pu_q[ppd_pkg::PU_F])}}))
    else $error("Port F input or pull-up state wrong.");

  a_g_alt_addr: assert property (
    g_asg_q[0] |=> port_g_pins_oe_o[0] &&
      (port_g_pins_o[0] == $past(extended_address_i[0])))
    else $error("Assigned port G pin does not carry the address.");

  a_g_upper_zero: assert property (
    s_rd(ppd_pkg::IDX_G_DIR) |=> avs_readdata_o[7:6] == 2'b00)
    else $error("Port G upper direction bits not zero.");

  a_g_asg_upper: assert property (
    s_rd(ppd_pkg::IDX_G_ASG) |=> avs_readdata_o[7:6] == 2'b00)
    else $error("Port G upper assignment bits not zero.");

  a_h_chip_sel: assert property (
    chip_select_en_i[3] |=> port_h_pins_oe_o[7] &&
      (port_h_pins_o[7] == $past(chip_select_i[3])))
    else $error("Chip select not routed to port H.");

  a_f_readback: assert property (
    s_rd(ppd_pkg::IDX_F_VAL) ##0 !mode_q |=> avs_readdata_o[7:0] ==
      (($past(f_dir_q) & $past(f_val_q)) | (~$past(f_dir_q) & $past(f_stable))))
    else $error("Port F readback mixes pins and latch wrongly.");

  a_g_pullup: assert property (
    !pu_q[ppd_pkg::PU_G] |=> port_g_pullup_o == 6'h00)
    else $error("Port G pull-up on while disabled.");

  a_mode_hold: assert property (
    !sys_rst_i |=> $stable(mode_q))
    else $error("Mode changed outside reset.");
endmodule : ppd_ports
`default_nettype wire

//--- verilog/ppd_sync.sv
// Three-stage pin synchroniser that accepts a level once stages agree.
`timescale 1ns/100ps
`default_nettype none
module ppd_sync #(
  parameter int unsigned W = 25
) (
  // Clock.
  input wire logic clock_i,
  // Pins in, stable levels out.
  ppd_pin_if.sync pins
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] st_q;
  logic [W-1:0] st_d;

  // No reset here: pin levels carry no reset value, and the strap
  // must keep flowing through while the block is held in reset.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    s1_q <= pins.raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    st_q <= st_d;
  end

  assign pins.stable = st_q;
endmodule : ppd_sync
`default_nettype wire
